// *** rbs_pkg.sv ***
package rbs_pkg;

  // ****************************************************************
  // register map (word offsets on the plain register port)
  // ****************************************************************
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  OFF_FUSE_DONE = 8'h00;  // bit0 fuse write done
  localparam logic [7:0]  OFF_FUSE_SEED = 8'h04;  // seed words, write once per power cycle
  localparam logic [7:0]  OFF_FUSE_CFG  = 8'h08;  // ordinary fuse word
  localparam logic [7:0]  OFF_FW_REQ    = 8'h0C;  // firmware request, read only here
  localparam logic [7:0]  OFF_MBOX_DATA = 8'h10;  // mailbox staging data
  localparam logic [7:0]  OFF_MBOX_EXEC = 8'h14;  // mailbox execute control
  localparam logic [7:0]  OFF_STATUS    = 8'h18;  // boot status
  localparam logic [7:0]  OFF_RESET_WHY = 8'h1C;  // reset reason, retained
  localparam int unsigned SEED_WORDS    = 12;     // 384 bit seed
  localparam int unsigned DONE_BIT      = 0;      // fuse done flag within its word
  localparam int unsigned EXEC_BIT      = 0;      // execute flag within its word

  // sizes the logic is built for
  localparam int unsigned MBOX_SIZE_BYTES = 131072;  // 128 kb staging sram
  localparam int unsigned ALGO_MAX        = 4;       // self-tested algorithms

  // reset reason encodings held in the power-good domain
  localparam logic [1:0] WHY_COLD       = 2'h0;
  localparam logic [1:0] WHY_WARM       = 2'h1;
  localparam logic [1:0] WHY_IMPACTLESS = 2'h2;

  // serial flash clock: 50 MHz system, 20 MHz target, slower never faster
  localparam int unsigned CLK_HZ   = 50_000_000;
  localparam int unsigned SCK_HZ   = 20_000_000;
  localparam int unsigned SCK_DIV  = (CLK_HZ + 2*SCK_HZ - 1) / (2*SCK_HZ);

  localparam logic [31:0] DEBUG_SEED_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    RBS_ST_UC_RST,
    RBS_ST_STRAP,
    RBS_ST_FUSE,
    RBS_ST_VAULT,
    RBS_ST_RUN,
    RBS_ST_FAIL
  } rbs_state_e;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } rbs_req_s;

  // strap inputs
  typedef struct packed {
    logic active_mode;
    logic debug;
    logic secure;
  } rbs_strap_s;

  // microcontroller side controls
  typedef struct packed {
    logic mbox_en;
    logic fw_req;
    logic fw_auth_ok;
    logic fmc_sig_ok;
    logic post_fail;
    logic [ALGO_MAX-1:0] conditional_self_test_fail;
    logic impactless;
  } rbs_uc_s;

endpackage : rbs_pkg

// *** rbs_boot_seq.sv ***
`timescale 1ns/1ns
// Summary of operation
// - straps for load mode and debug state are caught after reset release
// - debug straps replace secret assets with debug values before fuse use
// - fuse request raised; soc writes fuses then sets fuse done
// - fuse request drops right after the fuse done write
// - repeat writes to power-cycle-only registers such as the seed are silently dropped
// - after fuse done the seed moves into the key vault
// - mailbox writes are dropped until rom enables the mailbox
// - firmware request comes from a register also readable on the bus
// - passive mode execute write raises the microcontroller mailbox interrupt
// - runtime ready only after firmware is authenticated and loaded
// - active mode fetch uses single-io serial flash at 12.5 mhz, below the 20 mhz target
// - mailbox holds a 128 kb staging sram for firmware
// - on reset the microcontroller resets first, then the remaining logic
// - only power-good flops keep state over reset; sram is not cleared
// - after reset release the cold boot sequence reruns
// - retained reset reason tells warm, cold and impactless apart
// - failed pre-operational self-test leaves the block in boot failure
// - failed conditional self-test fails every dependent later operation
// - first mutable code starts only after its vendor signature checks
// - fuses take writes only after reset and before the fuse lock
module rbs_boot_seq
  import rbs_pkg::*;
#(
  parameter int unsigned MBOX_BYTES = 131072,
  parameter int unsigned N_ALGO     = 4
) (
  // clock, power-good and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_pwrgood,
  input  wire logic                    i_rst_b,
  // straps and self-test / microcontroller status
  input  wire rbs_pkg::rbs_strap_s     i_strap,
  input  wire rbs_pkg::rbs_uc_s        i_uc,
  input  wire logic [N_ALGO-1:0]       i_algo_req,
  // register port
  input  wire rbs_pkg::rbs_req_s       i_req,
  output logic [31:0]                  o_rdata,
  // handshake wires to the soc
  output logic                         o_fuse_request,
  output logic                         o_firmware_request_out,
  output logic                         o_runtime_ready_out,
  // internal controls
  output logic                         o_uc_rst_b,
  output logic                         o_mbox_irq,
  output logic [N_ALGO-1:0]            o_algo_fail,
  output logic                         o_fmc_start,
  output logic                         o_flash_sck,
  output logic [31:0]                  o_vault_seed,
  output logic                         o_vault_valid,
  output logic [1:0]                   o_reset_why
);
  import rbs_pkg::*;

  // elaboration checks on the parameters
  if (MBOX_BYTES != MBOX_SIZE_BYTES) begin : g_bad_mbox
    $error("mailbox must be 128 kb");
  end
  if (N_ALGO < 1 || N_ALGO > ALGO_MAX) begin : g_bad_algo
    $error("N_ALGO out of range");
  end

  localparam int unsigned MBOX_WORDS = MBOX_BYTES / 4;
  localparam int unsigned MB_AW      = $clog2(MBOX_WORDS);

  // ****************************************************************
  // staged reset: microcontroller first, remaining logic one cycle later
  // ****************************************************************
  logic rst_core_b_r;
  logic rst_sync_r;

  // first stage follows the ip reset pin asynchronously
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_r <= 1'b0;
    end else begin
      rst_sync_r <= 1'b1;
    end
  end

  // second stage asserts one cycle after the microcontroller reset, so the
  // core and its bus port stop only once the microcontroller is held
  always_ff @(posedge i_mclk or negedge i_pwrgood) begin
    if (!i_pwrgood) begin
      rst_core_b_r <= 1'b0;
    end else begin
      rst_core_b_r <= rst_sync_r;
    end
  end

  // ****************************************************************
  // power-good domain: seed, one-shot mask and reset reason survive ip reset
  // ****************************************************************
  logic [31:0]           seed_r [SEED_WORDS];
  logic [SEED_WORDS-1:0] seed_set_r;
  logic [1:0]            reset_why_r;
  logic                  booted_r;

  // ****************************************************************
  // boot state and core registers
  // ****************************************************************
  rbs_state_e       state_r;
  rbs_state_e       state_nxt;
  rbs_strap_s       strap_r;
  logic             fuse_done_r;
  logic             fuse_lock_r;
  logic [31:0]      fuse_cfg_r;
  logic [3:0]       seed_idx_r;
  logic [3:0]       wseed_idx_r;
  logic             vault_done_r;
  logic [N_ALGO-1:0] conditional_self_test_fail_r;
  logic             exec_pulse_r;
  logic [$clog2(SCK_DIV+1)-1:0] sck_cnt_r;
  logic             sck_r;
  logic [31:0]      rdata_r;

  // mailbox sram, never reset
  logic [31:0]      mbox_mem [MBOX_WORDS];
  logic [MB_AW-1:0] mbox_wptr_r;
  logic [MB_AW-1:0] mbox_rptr_r;

  // ****************************************************************
  // address decode and write gating
  // ****************************************************************
  wire hit_done  = i_req.addr == OFF_FUSE_DONE;
  wire hit_seed  = i_req.addr == OFF_FUSE_SEED;
  wire hit_cfg   = i_req.addr == OFF_FUSE_CFG;
  wire hit_mdata = i_req.addr == OFF_MBOX_DATA;
  wire hit_mexec = i_req.addr == OFF_MBOX_EXEC;
  wire fuse_open = rst_core_b_r && (state_r == RBS_ST_FUSE) && !fuse_lock_r;
  wire wr_done   = i_req.wr && hit_done && fuse_open && i_req.wdata[DONE_BIT];
  wire wr_cfg    = i_req.wr && hit_cfg && fuse_open;
  // seed word already set in this power cycle: write dropped silently
  wire wr_seed   = i_req.wr && hit_seed && fuse_open && !seed_set_r[wseed_idx_r];
  wire mbox_ok   = i_uc.mbox_en && (state_r == RBS_ST_RUN);
  wire wr_mdata  = i_req.wr && hit_mdata && mbox_ok;
  wire rd_mdata  = i_req.rd && hit_mdata && mbox_ok;
  wire wr_mexec  = i_req.wr && hit_mexec && mbox_ok && i_req.wdata[EXEC_BIT];
  wire boot_ok   = i_uc.fw_auth_ok && i_uc.fmc_sig_ok;

  // ****************************************************************
  // power-good retained state
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_pwrgood) begin
    if (!i_pwrgood) begin
      seed_set_r  <= '0;
      reset_why_r <= WHY_COLD;
      booted_r    <= 1'b0;
    end else begin
      if (wr_seed) begin
        seed_set_r[wseed_idx_r] <= 1'b1;
      end
      if (!rst_core_b_r && booted_r) begin
        reset_why_r <= i_uc.impactless ? WHY_IMPACTLESS : WHY_WARM;
      end
      if (o_runtime_ready_out) begin
        booted_r <= 1'b1;
      end
    end
  end

  // seed storage written under the one-shot mask, no reset needed
  always_ff @(posedge i_mclk) begin
    if (wr_seed) begin
      seed_r[wseed_idx_r] <= i_req.wdata;
    end
  end

  // ****************************************************************
  // boot state machine
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RBS_ST_UC_RST: state_nxt = RBS_ST_STRAP;
      RBS_ST_STRAP:  state_nxt = RBS_ST_FUSE;
      RBS_ST_FUSE:   if (fuse_done_r) state_nxt = RBS_ST_VAULT;
      RBS_ST_VAULT:  if (vault_done_r) state_nxt = RBS_ST_RUN;
      RBS_ST_RUN:    if (i_uc.post_fail) state_nxt = RBS_ST_FAIL;
      RBS_ST_FAIL:   state_nxt = RBS_ST_FAIL;
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      state_r <= RBS_ST_UC_RST;
      strap_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == RBS_ST_STRAP) begin
        strap_r <= i_strap;
      end
    end
  end

  // ****************************************************************
  // fuse population and lock
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      fuse_done_r <= 1'b0;
      fuse_lock_r <= 1'b0;
      fuse_cfg_r  <= '0;
      wseed_idx_r <= '0;
    end else begin
      if (wr_done) begin
        fuse_done_r <= 1'b1;
        fuse_lock_r <= 1'b1;
      end
      if (wr_cfg) begin
        fuse_cfg_r <= i_req.wdata;
      end
      if (i_req.wr && hit_seed && fuse_open) begin
        wseed_idx_r <= (wseed_idx_r == 4'(SEED_WORDS-1)) ? '0 : wseed_idx_r + 4'h1;
      end
    end
  end

  // ****************************************************************
  // key vault transfer, debug value substitution
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      seed_idx_r    <= '0;
      vault_done_r  <= 1'b0;
      o_vault_valid <= 1'b0;
      o_vault_seed  <= '0;
    end else begin
      o_vault_valid <= 1'b0;
      if (state_r == RBS_ST_VAULT && !vault_done_r) begin
        o_vault_valid <= 1'b1;
        o_vault_seed  <= strap_r.debug ? DEBUG_SEED_WORD : seed_r[seed_idx_r];
        seed_idx_r    <= seed_idx_r + 4'h1;
        vault_done_r  <= (seed_idx_r == 4'(SEED_WORDS-1));
      end
    end
  end

  // ****************************************************************
  // mailbox staging sram and execute interrupt
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (wr_mdata) begin
      mbox_mem[mbox_wptr_r] <= i_req.wdata;
    end
  end

  // write and read pointers walk the staged words; execute rewinds both
  always_ff @(posedge i_mclk or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      mbox_wptr_r  <= '0;
      mbox_rptr_r  <= '0;
      exec_pulse_r <= 1'b0;
    end else begin
      if (wr_mdata) begin
        mbox_wptr_r <= mbox_wptr_r + 1'b1;
      end
      if (rd_mdata) begin
        mbox_rptr_r <= mbox_rptr_r + 1'b1;
      end
      exec_pulse_r <= wr_mexec && !strap_r.active_mode;
      if (wr_mexec) begin
        mbox_wptr_r <= '0;
        mbox_rptr_r <= '0;
      end
    end
  end

  // ****************************************************************
  // conditional self-test failures latch per algorithm
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      conditional_self_test_fail_r <= '0;
    end else begin
      conditional_self_test_fail_r <= conditional_self_test_fail_r | i_uc.conditional_self_test_fail[N_ALGO-1:0];
    end
  end

  // ****************************************************************
  // serial flash clock divider, active mode only
  // ****************************************************************
  // a phase already begun is finished before the clock parks low
  wire sck_run = strap_r.active_mode && (state_r == RBS_ST_RUN || sck_r);

  always_ff @(posedge i_mclk or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      sck_cnt_r <= '0;
      sck_r     <= 1'b0;
    end else if (sck_run) begin
      if (sck_cnt_r == $bits(sck_cnt_r)'(SCK_DIV-1)) begin
        sck_cnt_r <= '0;
        sck_r     <= ~sck_r;
      end else begin
        sck_cnt_r <= sck_cnt_r + 1'b1;
      end
    end else begin
      sck_cnt_r <= '0;
      sck_r     <= 1'b0;
    end
  end

  // ****************************************************************
  // read data, one cycle after the read strobe
  // ****************************************************************
  wire [31:0] status_w = {24'h0, strap_r.debug, strap_r.active_mode,
                          fuse_lock_r, fuse_done_r, 1'b0, 3'(state_r)};
  wire [31:0] rd_mux =
      (i_req.addr == OFF_FUSE_DONE) ? {31'h0, fuse_done_r} :
      (i_req.addr == OFF_FUSE_CFG)  ? fuse_cfg_r :
      (i_req.addr == OFF_FW_REQ)    ? {31'h0, i_uc.fw_req} :
      (i_req.addr == OFF_STATUS)    ? status_w :
      (i_req.addr == OFF_RESET_WHY) ? {30'h0, reset_why_r} : 32'h0;

  always_ff @(posedge i_mclk or negedge rst_core_b_r) begin
    if (!rst_core_b_r) begin
      rdata_r <= '0;
    end else if (rd_mdata) begin
      rdata_r <= mbox_mem[mbox_rptr_r];
    end else if (i_req.rd) begin
      rdata_r <= rd_mux;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // microcontroller held until fuses done and vault loaded
  assign o_uc_rst_b  = i_rst_b && (state_r == RBS_ST_RUN || state_r == RBS_ST_FAIL);
  assign o_fuse_request          = (state_r == RBS_ST_FUSE) && !fuse_done_r;
  assign o_firmware_request_out  = i_uc.fw_req && (state_r == RBS_ST_RUN);
  assign o_runtime_ready_out     = boot_ok && (state_r == RBS_ST_RUN);
  assign o_fmc_start = boot_ok && (state_r == RBS_ST_RUN);
  assign o_mbox_irq  = exec_pulse_r;
  assign o_algo_fail = conditional_self_test_fail_r & i_algo_req;
  assign o_flash_sck = sck_r;
  assign o_rdata     = rdata_r;
  assign o_reset_why = reset_why_r;

endmodule : rbs_boot_seq

// *** rbs_boot_seq_chk.sv ***
`timescale 1ns/1ns
module rbs_boot_seq_chk
  import rbs_pkg::*;
#(
  parameter int unsigned N_ALGO = 4
) (
  // clock and reset
  input wire logic                i_mclk,
  input wire logic                i_rst_b,
  // watched inputs
  input wire rbs_pkg::rbs_uc_s    i_uc,
  input wire logic [N_ALGO-1:0]   i_algo_req,
  input wire rbs_pkg::rbs_req_s   i_req,
  // watched outputs
  input wire logic                o_fuse_request,
  input wire logic                o_firmware_request_out,
  input wire logic                o_runtime_ready_out,
  input wire logic                o_uc_rst_b,
  input wire logic                o_mbox_irq,
  input wire logic [N_ALGO-1:0]   o_algo_fail,
  input wire logic                o_fmc_start,
  input wire logic                o_flash_sck,
  input wire logic                o_vault_valid
);
  import rbs_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  // an accepted execute write, one cycle back
  logic exec_r;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) exec_r <= 1'b0;
    else exec_r <= i_req.wr && i_req.addr == OFF_MBOX_EXEC && i_req.wdata[0] && i_uc.mbox_en && o_uc_rst_b;
  end
  wire done_wr = i_req.wr && i_req.addr == OFF_FUSE_DONE && i_req.wdata[0] && o_fuse_request;

  // seed words leave for the vault on twelve cycles in a row
  property p_vault;
    done_wr |-> ##3 o_vault_valid [*8] ##1 o_vault_valid [*4];
  endproperty

  chk_fuse_drop: assert property (done_wr |=> !o_fuse_request)
    else $error("fuse request still high after done write");
  chk_uc_held: assert property (o_fuse_request |-> !o_uc_rst_b)
    else $error("microcontroller released during fuse phase");
  chk_vault_seq: assert property (p_vault)
    else $error("vault transfer missing or short");
  chk_irq_cause: assert property (o_mbox_irq |-> exec_r ##1 !o_mbox_irq)
    else $error("mailbox interrupt without enabled execute write");
  chk_rt_gate: assert property (o_runtime_ready_out |-> i_uc.fw_auth_ok && i_uc.fmc_sig_ok && o_uc_rst_b)
    else $error("runtime ready before firmware accepted");
  chk_fmc_gate: assert property (o_fmc_start |-> i_uc.fmc_sig_ok)
    else $error("first mutable code started without signature");
  chk_fw_wire: assert property (o_firmware_request_out |-> i_uc.fw_req)
    else $error("firmware request wire not from its register");
  chk_algo_mask: assert property (|o_algo_fail |-> (o_algo_fail & ~i_algo_req) == '0)
    else $error("algorithm failure reported for unused algorithm");
  chk_sck_rate: assert property ($changed(o_flash_sck) |=> $stable(o_flash_sck))
    else $error("serial clock faster than two cycles per phase");

  cover property (o_mbox_irq);
  cover property (o_runtime_ready_out);
  cover property (done_wr);
endmodule : rbs_boot_seq_chk

bind rbs_boot_seq rbs_boot_seq_chk #(.N_ALGO(N_ALGO)) rbs_boot_seq_chk_inst (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_uc(i_uc), .i_algo_req(i_algo_req), .i_req(i_req),
  .o_fuse_request(o_fuse_request), .o_firmware_request_out(o_firmware_request_out),
  .o_runtime_ready_out(o_runtime_ready_out), .o_uc_rst_b(o_uc_rst_b),
  .o_mbox_irq(o_mbox_irq), .o_algo_fail(o_algo_fail), .o_fmc_start(o_fmc_start),
  .o_flash_sck(o_flash_sck), .o_vault_valid(o_vault_valid));

// *** rbs_soc_model.sv ***
`timescale 1ns/1ns
module rbs_soc_model (
  // controls from the bench
  input  wire logic i_mclk,
  input  wire logic i_pwr_on,
  input  wire logic i_run,
  // power and reset to the device
  output logic      o_pwrgood,
  output logic      o_rst_b
);
  logic [1:0] hold_r = 2'h0;
  logic       pg_r   = 1'b0;

  // reset leaves only once power-good has been steady for three cycles
  always_ff @(posedge i_mclk) begin
    pg_r <= i_pwr_on;
    if (!pg_r || !i_run) hold_r <= 2'h0;
    else if (hold_r != 2'h3) hold_r <= hold_r + 2'h1;
  end
  assign o_pwrgood = pg_r;
  assign o_rst_b   = (hold_r == 2'h3);
endmodule : rbs_soc_model

// *** rbs_boot_seq_tb.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end
`define WAIT_HI(s) begin n = 0; while ((s) !== 1'b1 && n < 300) begin @(posedge i_mclk); \
  n++; end if (n >= 300) begin mismatches++; close_out(); end end
module rbs_boot_seq_tb;
  import rbs_pkg::*;
  localparam int unsigned N_ALGO = 4;
  logic              i_mclk = 1'b0, pwr_on = 1'b0, run = 1'b0, i_pwrgood, i_rst_b;
  rbs_strap_s        i_strap = '0;
  rbs_uc_s           i_uc = '0;
  logic [N_ALGO-1:0] i_algo_req = '0, o_algo_fail;
  rbs_req_s          i_req = '0;
  logic [31:0]       o_rdata, o_vault_seed, rd_v;
  logic              o_fuse_request, o_firmware_request_out, o_runtime_ready_out, o_uc_rst_b;
  logic              o_mbox_irq, o_fmc_start, o_flash_sck, o_vault_valid;
  logic [1:0]        o_reset_why;
  int                mismatches = 0, tests_run = 0, n, irqs = 0, sck_n = 0, s0;
  logic [31:0]       vq[$];

  always #10 i_mclk = ~i_mclk;
  // tally interrupt pulses, vault words and serial clock changes
  always @(posedge i_mclk) begin
    if (o_mbox_irq === 1'b1) irqs++;
    if (o_vault_valid === 1'b1) vq.push_back(o_vault_seed);
  end
  always @(o_flash_sck) sck_n++;

  rbs_soc_model rbs_soc_model_inst (.i_mclk(i_mclk), .i_pwr_on(pwr_on), .i_run(run),
    .o_pwrgood(i_pwrgood), .o_rst_b(i_rst_b));
  rbs_boot_seq #(.MBOX_BYTES(131072), .N_ALGO(N_ALGO)) rbs_boot_seq_inst (
    .i_mclk(i_mclk), .i_pwrgood(i_pwrgood), .i_rst_b(i_rst_b), .i_strap(i_strap),
    .i_uc(i_uc), .i_algo_req(i_algo_req), .i_req(i_req), .o_rdata(o_rdata),
    .o_fuse_request(o_fuse_request), .o_firmware_request_out(o_firmware_request_out),
    .o_runtime_ready_out(o_runtime_ready_out), .o_uc_rst_b(o_uc_rst_b),
    .o_mbox_irq(o_mbox_irq), .o_algo_fail(o_algo_fail), .o_fmc_start(o_fmc_start),
    .o_flash_sck(o_flash_sck), .o_vault_seed(o_vault_seed), .o_vault_valid(o_vault_valid),
    .o_reset_why(o_reset_why));

  // one-cycle register write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    i_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    i_req.rd <= 1'b0;
    #1 rd_v = o_rdata;
  endtask : rd

  // soc fuse fill from base, then vault words against expected base plus step times index
  task automatic fuse_pass(input logic [31:0] base, input logic [31:0] eb, input logic [31:0] st);
    `WAIT_HI(o_fuse_request)
    vq.delete();
    for (int i = 0; i < 12; i++) wr(OFF_FUSE_SEED, base + i);
    wr(OFF_FUSE_SEED, 32'hDEADBEEF);
    wr(OFF_FUSE_CFG, 32'h5);
    wr(OFF_FUSE_DONE, 32'h1);
    #1 `CHK("fuse_req", 1'b0, o_fuse_request)
    `WAIT_HI(o_uc_rst_b)
    `CHK("vault_n", 12, vq.size())
    for (int i = 0; i < 12 && i < vq.size(); i++) `CHK("vault", eb + st * i, vq[i])
  endtask : fuse_pass

  task close_out;
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  // cold boot, mailbox, handshakes, warm reset, debug power cycle, failure
  initial begin
    repeat (5) @(posedge i_mclk);
    pwr_on <= 1'b1;
    @(posedge i_mclk);
    run <= 1'b1;
    fuse_pass(32'hA0, 32'hA0, 32'h1);
    `CHK("why", WHY_COLD, o_reset_why)
    wr(OFF_FUSE_CFG, 32'h9);
    rd(OFF_FUSE_CFG);
    `CHK("cfg_lock", 32'h5, rd_v)
    wr(OFF_MBOX_DATA, 32'h11);
    wr(OFF_MBOX_EXEC, 32'h1);
    repeat (3) @(posedge i_mclk);
    `CHK("irq_off", 0, irqs)
    i_uc.mbox_en <= 1'b1;
    wr(OFF_MBOX_DATA, 32'h22);
    rd(OFF_MBOX_DATA);
    `CHK("mbox", 32'h22, rd_v)
    wr(OFF_MBOX_EXEC, 32'h1);
    repeat (3) @(posedge i_mclk);
    `CHK("irq_on", 1, irqs)
    i_uc.fw_req <= 1'b1;
    rd(OFF_FW_REQ);
    `CHK("fw_wire", 1'b1, o_firmware_request_out)
    `CHK("fw_reg", 1'b1, rd_v[0])
    @(posedge i_mclk);
    i_uc.fw_auth_ok <= 1'b1;
    repeat (2) @(posedge i_mclk);
    `CHK("rt_half", 1'b0, o_runtime_ready_out)
    i_uc.fmc_sig_ok <= 1'b1;
    repeat (2) @(posedge i_mclk);
    `CHK("rt", 1'b1, o_runtime_ready_out)
    `CHK("fmc", 1'b1, o_fmc_start)
    i_uc.conditional_self_test_fail <= 4'h5;
    i_algo_req <= 4'h3;
    repeat (2) @(posedge i_mclk);
    i_uc.conditional_self_test_fail <= 4'h0;
    repeat (2) @(posedge i_mclk);
    `CHK("algo", 4'h1, o_algo_fail)
    run <= 1'b0;
    repeat (2) @(posedge i_mclk);
    `CHK("uc_rst", 1'b0, o_uc_rst_b)
    `CHK("core_late", 1'b1, o_runtime_ready_out)
    @(posedge i_mclk);
    `CHK("rt_rst", 1'b0, o_runtime_ready_out)
    run <= 1'b1;
    i_uc <= '0;
    fuse_pass(32'hB0, 32'hA0, 32'h1);
    `CHK("why_w", WHY_WARM, o_reset_why)
    i_uc.impactless <= 1'b1;
    run <= 1'b0;
    repeat (3) @(posedge i_mclk);
    run <= 1'b1;
    `WAIT_HI(o_fuse_request)
    `CHK("why_i", WHY_IMPACTLESS, o_reset_why)
    run <= 1'b0;
    pwr_on <= 1'b0;
    i_strap <= '{active_mode: 1'b1, debug: 1'b1, secure: 1'b0};
    repeat (3) @(posedge i_mclk);
    pwr_on <= 1'b1;
    @(posedge i_mclk);
    run <= 1'b1;
    fuse_pass(32'hC0, DEBUG_SEED_WORD, 32'h0);
    `CHK("why_c", WHY_COLD, o_reset_why)
    s0 = sck_n;
    repeat (16) @(posedge i_mclk);
    `CHK("sck", 8, sck_n - s0)
    i_uc <= '{fw_auth_ok: 1'b1, fmc_sig_ok: 1'b1, post_fail: 1'b1, default: '0};
    repeat (2) @(posedge i_mclk);
    rd(OFF_STATUS);
    `CHK("state", RBS_ST_FAIL, rd_v[2:0])
    `CHK("rt_fail", 1'b0, o_runtime_ready_out)
    close_out();
  end
endmodule : rbs_boot_seq_tb
